// ===== hw/hrs_pkg.sv
package hrs_pkg;
  // Clock
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;

  // Times in their printed units
  localparam int T_RST_MIN_US = 1;
  localparam int T_RECOVER_US = 500;
  localparam int T_ATTACH_MAX_MS = 100;
  localparam real T_EEPROM_MAX_MS = 99.5;
  localparam int T_LOAD_MAX_MS = 300;
  localparam int T_HOST_WAIT_MS = 100;
  localparam int T_REQ_MAX_MS = 5;

  // Cycle counts (least times round up, longest times round down)
  localparam int RST_MIN_CYC = T_RST_MIN_US * CYC_PER_US;
  localparam int RECOVER_CYC = T_RECOVER_US * CYC_PER_US;
  localparam int ATTACH_MAX_CYC = T_ATTACH_MAX_MS * CYC_PER_MS;
  localparam int EEPROM_MAX_CYC = $rtoi(T_EEPROM_MAX_MS * CYC_PER_MS);
  localparam int LOAD_MAX_CYC = T_LOAD_MAX_MS * CYC_PER_MS;
  localparam int HOST_WAIT_CYC = T_HOST_WAIT_MS * CYC_PER_MS;
  localparam int REQ_MAX_CYC = T_REQ_MAX_MS * CYC_PER_MS;
  // Own latencies, far inside the limits above
  localparam int APPLY_CYC = 16;
  localparam int REQ_CYC = 8;
  localparam int BUSRST_CYC = 100;
  localparam int CNT_W = 22;

  // Configuration source select strap
  localparam logic [1:0] CFG_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] CFG_SEL_SMBUS = 2'h1;

  // Configuration word fields
  localparam int CFGW_FIX_LSB = 0;
  localparam int CFGW_DIS_LSB = 4;

  // Upstream request kinds
  localparam logic [1:0] REQ_GET_STATUS = 2'h0;
  localparam logic [1:0] REQ_SET_ADDR = 2'h1;
  localparam logic [1:0] REQ_SET_CFG = 2'h2;

  // Host APB map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_REQ = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_CFG = 12'h00c;
  localparam int CTL_RST = 0;
  localparam int CTL_BUSRST = 1;
  localparam int CTL_SUSP = 2;
  localparam int CTL_CFGRDY = 3;
  localparam int CTL_BUSPWR = 4;
  localparam int CTL_BCEN = 5;
  localparam int CTL_SEL_LSB = 8;
  localparam int CTL_FIX_LSB = 12;
  localparam logic [15:0] CTRL_MASK = 16'h333d;
  localparam logic [15:0] CTRL_RST_VAL = 16'h0001;
  localparam int REQ_KIND_LSB = 8;
  localparam int ST_ATTACH = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_DONE = 2;
  localparam int ST_LATE = 3;
  localparam int ST_RSTHELD = 4;
  localparam int ST_BRST = 5;
  localparam int ST_PWR_LSB = 8;
  localparam int ST_FETCH = 12;
endpackage

// ===== hw/hrs_link_if.sv
`timescale 1ns/10ps
interface hrs_link_if;
  // Host to device
  logic hw_reset_n;
  logic bus_reset;
  logic suspend_req;
  logic cfg_ready;
  logic [7:0] cfg_data;
  logic req_valid;
  logic [1:0] req_kind;
  logic [6:0] req_data;
  logic [1:0] strap_cfg_sel;
  logic charge_support_enable;
  logic [1:0] fixed_device_strap;
  // Device to host
  logic [3:0] port_power_enable;
  logic [3:0] port_enable;
  logic phy_enable;
  logic osc_run;
  logic pll_run;
  logic [3:0] led;
  logic usb_attach;
  logic tt_clear;
  logic suspended;
  logic cfg_fetch;
  logic req_ack;

  modport dev (
    input hw_reset_n, bus_reset, suspend_req, cfg_ready, cfg_data,
    input req_valid, req_kind, req_data, strap_cfg_sel,
    input charge_support_enable, fixed_device_strap,
    output port_power_enable, port_enable, phy_enable, osc_run, pll_run,
    output led, usb_attach, tt_clear, suspended, cfg_fetch, req_ack
  );
  modport hst (
    output hw_reset_n, bus_reset, suspend_req, cfg_ready, cfg_data,
    output req_valid, req_kind, req_data, strap_cfg_sel,
    output charge_support_enable, fixed_device_strap,
    input port_power_enable, port_enable, phy_enable, osc_run, pll_run,
    input led, usb_attach, tt_clear, suspended, cfg_fetch, req_ack
  );
endinterface

// ===== hw/hrs_dev.sv
`timescale 1ns/10ps
// Summary of operation
// RULE_01: Hardware reset held low at least 1 us.
// RULE_02: In reset, ports off, power off unless charging.
// RULE_03: In reset, PHYs disabled, pairs float.
// RULE_04: Reset aborts transactions, keeps no state.
// RULE_05: Reset returns configuration registers to zero.
// RULE_06: In reset, oscillator and PLL stopped.
// RULE_07: In reset, all LEDs off.
// RULE_08: Operational by 500 us, then fetch configuration.
// RULE_09: Strap mode: outputs inactive within 2 us.
// RULE_10: Strap mode: attach within 100 ms.
// RULE_11: EEPROM mode: read and apply within 99.5 ms.
// RULE_12: SMBus host loads code within 300 ms.
// RULE_13: SMBus mode: apply and attach within 100 ms.
// RULE_14: Self-powered load time unbounded; bus-powered bounded.
// RULE_15: Host waits 100 ms after attach before reset.
// RULE_16: Each upstream request completes within 5 ms.
// RULE_17: Bus reset sets device address to zero.
// RULE_18: Bus reset unconfigures and clears TT buffers.
// RULE_19: Bus reset drops port power unless charging.
// RULE_20: Bus reset wakes a suspended device.
// RULE_21: Bus reset never passed to downstream ports.
// RULE_22: Fixed-device straps read as tied level.
// RULE_23: Straps latched once at reset release.
module hrs_dev #(
  parameter int RECOVER_CYC = hrs_pkg::RECOVER_CYC,
  parameter int EEPROM_MAX_CYC = hrs_pkg::EEPROM_MAX_CYC,
  parameter int APPLY_CYC = hrs_pkg::APPLY_CYC,
  parameter int REQ_CYC = hrs_pkg::REQ_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Link
  hrs_link_if.dev lnk,
  // Device status
  output logic [6:0] usb_addr,
  output logic usb_configured,
  output logic [1:0] fixed_port_mask,
  output logic operational
);
  localparam int CW = hrs_pkg::CNT_W;
  localparam int SW = 27;

  typedef enum logic [2:0] {
    ST_HWRST, ST_RECOVER, ST_FETCH, ST_APPLY, ST_ATTACHED
  } hrs_dev_state_e;

  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  logic hwrst_n, brst, susp, cready, rvalid, bcen;
  logic [1:0] sel, fstrap, rkind;
  logic [7:0] cdata;
  logic [6:0] rdata;
  logic in_hw;

  hrs_dev_state_e state_ff, nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [1:0] sel_ff, fstrap_ff;
  logic bc_ff, smbus;
  logic [7:0] cfg_ff;
  logic [3:0] dis;
  logic bc_now;
  logic [6:0] addr_ff;
  logic cfgd_ff, susp_ff, tt_ff, attach_ff, fetch_ff;
  logic busy_ff, ack_ff;
  logic [CW-1:0] rcnt_ff;
  logic [1:0] kind_ff;
  logic [6:0] data_ff;
  logic [1:0] fix_ff;
  logic [3:0] pwr_ff, pen_ff, led_ff;
  logic phy_ff, osc_ff, pll_ff;

  // Every pin passes two flops before use
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {lnk.hw_reset_n, lnk.bus_reset, lnk.suspend_req,
                lnk.cfg_ready, lnk.req_valid, lnk.charge_support_enable,
                lnk.strap_cfg_sel, lnk.fixed_device_strap, lnk.cfg_data,
                lnk.req_kind, lnk.req_data};
      s2_ff <= s1_ff;
    end
  end
  assign {hwrst_n, brst, susp, cready, rvalid, bcen, sel, fstrap, cdata,
          rkind, rdata} = s2_ff;
  // Host keeps the pin low long enough; any low level is obeyed
  assign in_hw = ~hwrst_n; // RULE_01

  assign smbus = (sel_ff == hrs_pkg::CFG_SEL_SMBUS);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HWRST: nxt_state = ST_RECOVER;
      ST_RECOVER: begin
        if (cnt_ff == CW'(RECOVER_CYC - 1)) begin // RULE_08
          if (sel_ff == hrs_pkg::CFG_SEL_DEFAULT) begin
            nxt_state = ST_APPLY;
          end else begin
            nxt_state = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        // SMBus load may take as long as the host needs
        if (cready) begin // RULE_14
          nxt_state = ST_APPLY;
        end else if (!smbus && cnt_ff == CW'(EEPROM_MAX_CYC - 1)) begin
          // Silent EEPROM: fall back to defaults on time
          nxt_state = ST_APPLY; // RULE_11
        end
      end
      ST_APPLY: begin
        if (cnt_ff == CW'(APPLY_CYC - 1)) begin // RULE_10 RULE_13
          nxt_state = ST_ATTACHED;
        end
      end
      ST_ATTACHED: nxt_state = ST_ATTACHED;
      default: nxt_state = ST_HWRST;
    endcase
    if (in_hw) begin
      nxt_state = ST_HWRST;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= ST_HWRST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (state_ff != ST_ATTACHED) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Straps sampled on the release cycle only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_ff <= '0;
      fstrap_ff <= '0;
      bc_ff <= 1'b0;
    end else if (state_ff == ST_HWRST && !in_hw) begin
      sel_ff <= sel; // RULE_23
      fstrap_ff <= fstrap;
      bc_ff <= bcen;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || in_hw) begin
      cfg_ff <= '0; // RULE_05
    end else if (state_ff == ST_FETCH && cready) begin
      cfg_ff <= cdata; // RULE_11 RULE_13
    end
  end
  assign dis = cfg_ff[hrs_pkg::CFGW_DIS_LSB +: 4];

  always_ff @(posedge clk_sys) begin
    if (reset || in_hw) begin
      fix_ff <= '0;
    end else if (state_ff == ST_APPLY) begin
      if (sel_ff == hrs_pkg::CFG_SEL_DEFAULT) begin
        fix_ff <= fstrap_ff; // RULE_22
      end else begin
        fix_ff <= cfg_ff[hrs_pkg::CFGW_FIX_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fetch_ff <= 1'b0;
      attach_ff <= 1'b0;
    end else begin
      fetch_ff <= (nxt_state == ST_FETCH); // RULE_08
      attach_ff <= (nxt_state == ST_ATTACHED); // RULE_10 RULE_13
    end
  end

  // Upstream requests: four-phase handshake
  always_ff @(posedge clk_sys) begin
    if (reset || in_hw || brst) begin
      busy_ff <= 1'b0; // RULE_04
      ack_ff <= 1'b0;
      rcnt_ff <= '0;
      kind_ff <= '0;
      data_ff <= '0;
    end else if (busy_ff) begin
      rcnt_ff <= rcnt_ff + 1'b1;
      if (rcnt_ff == CW'(REQ_CYC - 1)) begin // RULE_16
        busy_ff <= 1'b0;
        ack_ff <= 1'b1;
      end
    end else if (ack_ff) begin
      ack_ff <= rvalid;
    end else if (rvalid && state_ff == ST_ATTACHED) begin
      busy_ff <= 1'b1;
      rcnt_ff <= '0;
      kind_ff <= rkind;
      data_ff <= rdata;
    end
  end

  wire req_fin = busy_ff && rcnt_ff == CW'(REQ_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (reset || in_hw || brst) begin
      addr_ff <= '0; // RULE_17
    end else if (req_fin && kind_ff == hrs_pkg::REQ_SET_ADDR) begin
      addr_ff <= data_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || in_hw || brst) begin
      cfgd_ff <= 1'b0; // RULE_18
    end else if (req_fin && kind_ff == hrs_pkg::REQ_SET_CFG) begin
      cfgd_ff <= data_ff[0];
    end
  end

  // Downstream ports see no reset from here, only loss of enable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tt_ff <= 1'b0;
      susp_ff <= 1'b0;
    end else begin
      tt_ff <= in_hw | brst; // RULE_18 RULE_21
      susp_ff <= susp & ~brst & ~in_hw & attach_ff; // RULE_20
    end
  end

  assign bc_now = in_hw ? bcen : bc_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwr_ff <= '0;
      pen_ff <= '0;
      led_ff <= '0;
    end else if (in_hw || brst || !cfgd_ff) begin
      pwr_ff <= {4{bc_now}}; // RULE_02 RULE_19
      pen_ff <= '0; // RULE_02 RULE_09
      led_ff <= '0; // RULE_07
    end else begin
      pwr_ff <= ~dis | {4{bc_now}};
      pen_ff <= ~dis;
      led_ff <= pen_ff;
    end
  end

  // PLL follows the oscillator by a cycle so it never runs unclocked
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phy_ff <= 1'b0;
      osc_ff <= 1'b0;
      pll_ff <= 1'b0;
    end else begin
      phy_ff <= ~in_hw; // RULE_03
      osc_ff <= ~in_hw; // RULE_06
      pll_ff <= osc_ff & ~in_hw; // RULE_06
    end
  end

  assign lnk.port_power_enable = pwr_ff;
  assign lnk.port_enable = pen_ff;
  assign lnk.phy_enable = phy_ff;
  assign lnk.osc_run = osc_ff;
  assign lnk.pll_run = pll_ff;
  assign lnk.led = led_ff;
  assign lnk.usb_attach = attach_ff;
  assign lnk.tt_clear = tt_ff;
  assign lnk.suspended = susp_ff;
  assign lnk.cfg_fetch = fetch_ff;
  assign lnk.req_ack = ack_ff;
  assign usb_addr = addr_ff;
  assign usb_configured = cfgd_ff;
  assign fixed_port_mask = fix_ff;
  assign operational = attach_ff;
endmodule // hrs_dev

// ===== hw/hrs_host.sv
`timescale 1ns/10ps
module hrs_host #(
  parameter int RST_MIN_CYC = hrs_pkg::RST_MIN_CYC,
  parameter int HOST_WAIT_CYC = hrs_pkg::HOST_WAIT_CYC,
  parameter int LOAD_MAX_CYC = hrs_pkg::LOAD_MAX_CYC,
  parameter int BUSRST_CYC = hrs_pkg::BUSRST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  hrs_link_if.hst lnk
);
  localparam int CW = hrs_pkg::CNT_W;

  logic [6:0] s1_ff, s2_ff;
  logic attach_s, ack_s, fetch_s;
  logic [3:0] pwr_s;
  logic [15:0] ctrl_ff;
  logic [7:0] cfgd_ff;
  logic rstn_ff, pend_ff, brst_ff, rv_ff, done_ff, late_ff;
  logic [1:0] kind_ff;
  logic [6:0] data_ff;
  logic [CW-1:0] rcnt_ff, acnt_ff, bcnt_ff, lcnt_ff;
  logic [31:0] rd_ff, stat;
  logic setup, wr, hit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {lnk.usb_attach, lnk.req_ack, lnk.cfg_fetch,
                lnk.port_power_enable};
      s2_ff <= s1_ff;
    end
  end
  assign {attach_s, ack_s, fetch_s, pwr_s} = s2_ff;

  // Zero-wait APB: read data captured in the setup cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign hit = paddr == hrs_pkg::ADDR_CTRL || paddr == hrs_pkg::ADDR_REQ ||
               paddr == hrs_pkg::ADDR_STAT || paddr == hrs_pkg::ADDR_CFG;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    stat = '0;
    stat[hrs_pkg::ST_ATTACH] = attach_s;
    stat[hrs_pkg::ST_BUSY] = rv_ff;
    stat[hrs_pkg::ST_DONE] = done_ff;
    stat[hrs_pkg::ST_LATE] = late_ff;
    stat[hrs_pkg::ST_RSTHELD] = ~rstn_ff;
    stat[hrs_pkg::ST_BRST] = pend_ff;
    stat[hrs_pkg::ST_PWR_LSB +: 4] = pwr_s;
    stat[hrs_pkg::ST_FETCH] = fetch_s;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_ff <= '0;
    end else if (setup && !pwrite) begin
      case (paddr)
        hrs_pkg::ADDR_CTRL: rd_ff <= {16'h0000, ctrl_ff};
        hrs_pkg::ADDR_REQ:
          rd_ff <= {22'h0, kind_ff, 1'b0, data_ff};
        hrs_pkg::ADDR_STAT: rd_ff <= stat;
        hrs_pkg::ADDR_CFG: rd_ff <= {24'h000000, cfgd_ff};
        default: rd_ff <= '0;
      endcase
    end
  end
  assign prdata = rd_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_ff <= hrs_pkg::CTRL_RST_VAL;
      cfgd_ff <= '0;
    end else if (wr && paddr == hrs_pkg::ADDR_CTRL) begin
      ctrl_ff <= pwdata[15:0] & hrs_pkg::CTRL_MASK;
    end else if (wr && paddr == hrs_pkg::ADDR_CFG) begin
      cfgd_ff <= pwdata[7:0];
    end
  end

  // Release waits until the pin has been low the least reset time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rstn_ff <= 1'b0;
      rcnt_ff <= '0;
    end else if (ctrl_ff[hrs_pkg::CTL_RST]) begin
      rstn_ff <= 1'b0;
      if (rstn_ff) begin
        rcnt_ff <= '0;
      end else if (rcnt_ff != CW'(RST_MIN_CYC - 1)) begin
        rcnt_ff <= rcnt_ff + 1'b1;
      end
    end else if (!rstn_ff) begin
      if (rcnt_ff == CW'(RST_MIN_CYC - 1)) begin
        rstn_ff <= 1'b1; // RULE_01
      end else begin
        rcnt_ff <= rcnt_ff + 1'b1;
      end
    end
  end

  // Bus reset is held back until attach has stood the host wait
  always_ff @(posedge clk_sys) begin
    if (reset || !attach_s) begin
      acnt_ff <= '0;
    end else if (acnt_ff != CW'(HOST_WAIT_CYC - 1)) begin
      acnt_ff <= acnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !rstn_ff) begin
      pend_ff <= 1'b0;
      brst_ff <= 1'b0;
      bcnt_ff <= '0;
    end else if (brst_ff) begin
      bcnt_ff <= bcnt_ff + 1'b1;
      if (bcnt_ff == CW'(BUSRST_CYC - 1)) begin
        brst_ff <= 1'b0;
        pend_ff <= 1'b0;
      end
    end else if (pend_ff) begin
      bcnt_ff <= '0;
      brst_ff <= acnt_ff == CW'(HOST_WAIT_CYC - 1); // RULE_15
    end else if (wr && paddr == hrs_pkg::ADDR_CTRL) begin
      pend_ff <= pwdata[hrs_pkg::CTL_BUSRST];
    end
  end

  // Load time is policed only for bus-powered boards
  always_ff @(posedge clk_sys) begin
    if (reset || !fetch_s || ctrl_ff[hrs_pkg::CTL_CFGRDY]) begin
      lcnt_ff <= '0;
    end else if (lcnt_ff != CW'(LOAD_MAX_CYC - 1)) begin
      lcnt_ff <= lcnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      late_ff <= 1'b0;
    end else if (ctrl_ff[hrs_pkg::CTL_BUSPWR] && fetch_s &&
                 !ctrl_ff[hrs_pkg::CTL_CFGRDY] &&
                 lcnt_ff == CW'(LOAD_MAX_CYC - 1)) begin
      late_ff <= 1'b1; // RULE_12 RULE_14
    end else if (wr && paddr == hrs_pkg::ADDR_STAT &&
                 pwdata[hrs_pkg::ST_LATE]) begin
      late_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rv_ff <= 1'b0;
      done_ff <= 1'b0;
      kind_ff <= '0;
      data_ff <= '0;
    end else if (rv_ff) begin
      if (ack_s) begin
        rv_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end else if (wr && paddr == hrs_pkg::ADDR_REQ && !ack_s) begin
      rv_ff <= 1'b1;
      done_ff <= 1'b0;
      kind_ff <= pwdata[hrs_pkg::REQ_KIND_LSB +: 2];
      data_ff <= pwdata[6:0];
    end
  end

  assign lnk.hw_reset_n = rstn_ff;
  assign lnk.bus_reset = brst_ff;
  assign lnk.suspend_req = ctrl_ff[hrs_pkg::CTL_SUSP];
  assign lnk.cfg_ready = ctrl_ff[hrs_pkg::CTL_CFGRDY];
  assign lnk.cfg_data = cfgd_ff;
  assign lnk.req_valid = rv_ff;
  assign lnk.req_kind = kind_ff;
  assign lnk.req_data = data_ff;
  assign lnk.strap_cfg_sel = ctrl_ff[hrs_pkg::CTL_SEL_LSB +: 2];
  assign lnk.charge_support_enable = ctrl_ff[hrs_pkg::CTL_BCEN];
  assign lnk.fixed_device_strap = ctrl_ff[hrs_pkg::CTL_FIX_LSB +: 2];
endmodule // hrs_host

// ===== testbench/hrs_link_chk_sva.sv
`timescale 1ns/10ps
module hrs_link_chk #(
  parameter int RECOVER_CYC = 20,
  parameter int EEPROM_MAX_CYC = 50,
  parameter int APPLY_CYC = hrs_pkg::APPLY_CYC,
  parameter int REQ_CYC = hrs_pkg::REQ_CYC,
  parameter int RST_MIN_CYC = 10,
  parameter int HOST_WAIT_CYC = 30
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host to device
  input wire logic hw_reset_n,
  input wire logic bus_reset,
  input wire logic cfg_ready,
  input wire logic req_valid,
  input wire logic [1:0] strap_cfg_sel,
  input wire logic charge_support_enable,
  // Device to host
  input wire logic [3:0] port_power_enable,
  input wire logic [3:0] port_enable,
  input wire logic phy_enable,
  input wire logic osc_run,
  input wire logic pll_run,
  input wire logic [3:0] led,
  input wire logic usb_attach,
  input wire logic tt_clear,
  input wire logic suspended,
  input wire logic cfg_fetch,
  input wire logic req_ack
);
  localparam int FETCH_MAX = RECOVER_CYC + 8;
  localparam int ATT_MAX = RECOVER_CYC + APPLY_CYC + 8;
  localparam int EE_MAX = EEPROM_MAX_CYC + APPLY_CYC + 8;
  localparam int APL_MAX = APPLY_CYC + 8;
  localparam int ACK_MAX = REQ_CYC + 8;
  logic [7:0] low_ff;
  logic [7:0] att_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Saturating, so a long wait never wraps into a short one
  always_ff @(posedge clk_sys) begin
    if (reset || hw_reset_n) low_ff <= 8'h00;
    else if (low_ff != 8'hff) low_ff <= low_ff + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (reset || !usb_attach) att_ff <= 8'h00;
    else if (att_ff != 8'hff) att_ff <= att_ff + 8'h01;
  end

  // Four samples cover the two-flop synchroniser and the output flop
  sequence s_held; (!hw_reset_n)[*4]; endsequence
  sequence s_up; $rose(hw_reset_n); endsequence

  AST_RST_MIN: assert property (
    s_up |-> int'(low_ff) >= RST_MIN_CYC) else $error("short hw reset");
  AST_RST_PORTS: assert property (
    s_held |-> port_enable == 4'h0 && led == 4'h0 && !phy_enable)
    else $error("ports live in hw reset");
  AST_RST_PWR: assert property (
    (!hw_reset_n && $stable(charge_support_enable))[*4] |->
    port_power_enable == {4{charge_support_enable}})
    else $error("port power wrong in hw reset");
  AST_RST_CLK: assert property (
    s_held ##1 !hw_reset_n |-> !osc_run && !pll_run)
    else $error("clocks run in hw reset");
  AST_RST_STATE: assert property (
    s_held |-> !usb_attach && !cfg_fetch && !req_ack)
    else $error("state kept in hw reset");
  AST_FETCH: assert property (
    s_up and strap_cfg_sel == hrs_pkg::CFG_SEL_SMBUS |->
    ##[1:FETCH_MAX] cfg_fetch) else $error("fetch late");
  AST_STRAP_ATT: assert property (
    s_up and strap_cfg_sel == hrs_pkg::CFG_SEL_DEFAULT |->
    ##[1:ATT_MAX] usb_attach) else $error("strap attach late");
  AST_EE_ATT: assert property (
    $rose(cfg_fetch) && strap_cfg_sel[1] |-> ##[1:EE_MAX] usb_attach)
    else $error("eeprom attach late");
  AST_SMB_HOLD: assert property (
    cfg_fetch && !cfg_ready && strap_cfg_sel == hrs_pkg::CFG_SEL_SMBUS
    |=> !usb_attach) else $error("attach before code load");
  AST_SMB_ATT: assert property (
    $rose(cfg_ready) && cfg_fetch |-> ##[1:APL_MAX] usb_attach)
    else $error("smbus attach late");
  AST_HOST_WAIT: assert property (
    $rose(bus_reset) |-> int'(att_ff) >= HOST_WAIT_CYC)
    else $error("bus reset too soon");
  AST_REQ_ACK: assert property (
    $rose(req_valid) && usb_attach && !bus_reset |-> ##[1:ACK_MAX] req_ack)
    else $error("request not acked");
  AST_BRST: assert property (
    (bus_reset && $stable(charge_support_enable))[*4] |-> tt_clear &&
    !suspended && port_enable == 4'h0 &&
    port_power_enable == {4{charge_support_enable}})
    else $error("bus reset effect missing");
endmodule // hrs_link_chk

// ===== testbench/test_hub_reset_config_sequencer.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < lim) begin \
  @(negedge clk_sys); n++; end `CHK("wait", 1'b1, 1'(c)) end
module test_hub_reset_config_sequencer;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] usb_addr;
  logic usb_configured;
  logic [1:0] fixed_port_mask;
  logic operational;
  logic [31:0] rd;
  logic err;
  int n;
  int bad_count = 0;
  int checks_done = 0;

  hrs_link_if u_hrs_link_if();
  hrs_host #(.RST_MIN_CYC(10), .HOST_WAIT_CYC(30), .LOAD_MAX_CYC(60))
    u_hrs_host (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(u_hrs_link_if.hst));
  hrs_dev #(.RECOVER_CYC(20), .EEPROM_MAX_CYC(50)) u_hrs_dev (
    .clk_sys(clk_sys), .reset(reset), .lnk(u_hrs_link_if.dev),
    .usb_addr(usb_addr),
    .usb_configured(usb_configured), .fixed_port_mask(fixed_port_mask),
    .operational(operational));
  hrs_link_chk u_hrs_link_chk (.clk_sys(clk_sys), .reset(reset),
    .hw_reset_n(u_hrs_link_if.hw_reset_n),
    .bus_reset(u_hrs_link_if.bus_reset),
    .cfg_ready(u_hrs_link_if.cfg_ready),
    .req_valid(u_hrs_link_if.req_valid),
    .strap_cfg_sel(u_hrs_link_if.strap_cfg_sel),
    .charge_support_enable(u_hrs_link_if.charge_support_enable),
    .port_power_enable(u_hrs_link_if.port_power_enable),
    .port_enable(u_hrs_link_if.port_enable),
    .phy_enable(u_hrs_link_if.phy_enable),
    .osc_run(u_hrs_link_if.osc_run), .pll_run(u_hrs_link_if.pll_run),
    .led(u_hrs_link_if.led), .usb_attach(u_hrs_link_if.usb_attach),
    .tt_clear(u_hrs_link_if.tt_clear),
    .suspended(u_hrs_link_if.suspended),
    .cfg_fetch(u_hrs_link_if.cfg_fetch), .req_ack(u_hrs_link_if.req_ack));

  always #50 clk_sys = ~clk_sys;

  // One APB transfer; ends on a falling edge so outputs have settled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask

  // Straps are set while held so they are latched at the release
  task automatic boot(input logic [31:0] c);
    apb(1'b1, hrs_pkg::ADDR_CTRL, c | 32'h1);
    apb(1'b1, hrs_pkg::ADDR_CTRL, c);
  endtask

  task automatic req(input logic [1:0] k, input logic [6:0] d);
    apb(1'b1, hrs_pkg::ADDR_REQ, {22'h0, k, 1'b0, d});
    `WAITC(u_hrs_link_if.req_ack, 40)
    `WAITC(!u_hrs_link_if.req_ack, 40)
    // Host refuses a new request until it has seen the ack fall
    apb(1'b0, hrs_pkg::ADDR_STAT, 32'h0);
    `CHK("done", 1'b1, rd[hrs_pkg::ST_DONE])
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    apb(1'b0, hrs_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b0, hrs_pkg::ADDR_STAT, 32'h0);
    `CHK("held", 1'b1, rd[hrs_pkg::ST_RSTHELD])
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'b1, err)
    `CHK("phy", 1'b0, u_hrs_link_if.phy_enable)
    `CHK("osc", 1'b0, u_hrs_link_if.osc_run)
    `CHK("power", 4'h0, u_hrs_link_if.port_power_enable)
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h21);
    `WAITC(u_hrs_link_if.port_power_enable == 4'hf, 10)
    boot(32'h2000);
    `WAITC(u_hrs_link_if.usb_attach, 60)
    `CHK("fixed", 2'b10, fixed_port_mask)
    `CHK("pll", 1'b1, u_hrs_link_if.pll_run)
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h1000);
    repeat (4) @(negedge clk_sys);
    `CHK("latched", 2'b10, fixed_port_mask)
    req(hrs_pkg::REQ_GET_STATUS, 7'h00);
    req(hrs_pkg::REQ_SET_ADDR, 7'h2a);
    `CHK("addr", 7'h2a, usb_addr)
    req(hrs_pkg::REQ_SET_CFG, 7'h01);
    `CHK("cfgd", 1'b1, usb_configured)
    `CHK("ports", 4'hf, u_hrs_link_if.port_enable)
    `WAITC(u_hrs_link_if.led == 4'hf, 4)
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h1004);
    `WAITC(u_hrs_link_if.suspended, 10)
    // Suspend stays requested so the wake comes from the bus reset
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h1006);
    `WAITC(u_hrs_link_if.bus_reset, 60)
    repeat (4) @(negedge clk_sys);
    `CHK("busaddr", 7'h00, usb_addr)
    `CHK("unconf", 1'b0, usb_configured)
    `CHK("tt", 1'b1, u_hrs_link_if.tt_clear)
    `CHK("wake", 1'b0, u_hrs_link_if.suspended)
    `CHK("bpower", 4'h0, u_hrs_link_if.port_power_enable)
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h1000);
    `WAITC(!u_hrs_link_if.bus_reset, 120)
    req(hrs_pkg::REQ_SET_ADDR, 7'h15);
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h1);
    repeat (5) @(negedge clk_sys);
    `CHK("hwaddr", 7'h00, usb_addr)
    `CHK("detach", 1'b0, u_hrs_link_if.usb_attach)
    `CHK("led", 4'h0, u_hrs_link_if.led)
    `CHK("osc2", 1'b0, u_hrs_link_if.osc_run)
    // Code load: port 0 fixed and disabled
    apb(1'b1, hrs_pkg::ADDR_CFG, 32'h11);
    boot(32'h110);
    `WAITC(u_hrs_link_if.cfg_fetch, 40)
    repeat (70) @(negedge clk_sys);
    `CHK("waitload", 1'b0, u_hrs_link_if.usb_attach)
    apb(1'b0, hrs_pkg::ADDR_STAT, 32'h0);
    `CHK("late", 1'b1, rd[hrs_pkg::ST_LATE])
    apb(1'b1, hrs_pkg::ADDR_CTRL, 32'h108);
    `WAITC(u_hrs_link_if.usb_attach, 30)
    `CHK("smbfix", 2'b01, fixed_port_mask)
    req(hrs_pkg::REQ_SET_CFG, 7'h01);
    `CHK("dis", 4'he, u_hrs_link_if.port_enable)
    boot(32'h200);
    `WAITC(u_hrs_link_if.cfg_fetch, 40)
    `WAITC(u_hrs_link_if.usb_attach, 80)
    summarize();
  end
endmodule // test_hub_reset_config_sequencer
